// >>> rtl/utcc_pkg.sv
// shared constants for the transceiver clock control block
package utcc_pkg;
  localparam int UTCC_AW = 8;
  localparam int UTCC_DW = 16;
  // device register byte offsets
  localparam logic [7:0] UTCC_TCC_OFS = 8'h00;
  localparam logic [7:0] UTCC_TLS_OFS = 8'h02;
  // transceiver_clock_control fields
  localparam int UTCC_XTAL_HI = 15;
  localparam int UTCC_XTAL_LO = 14;
  localparam int UTCC_OSC_BIT = 13;
  localparam int UTCC_REF_BIT = 12;
  localparam int UTCC_PLL_BIT = 11;
  localparam int UTCC_SCK_BIT = 10;
  localparam int UTCC_HSE_BIT = 7;
  localparam int UTCC_RPU_BIT = 4;
  localparam int UTCC_RUN_BIT = 0;
  localparam logic [15:0] UTCC_TCC_RST = 16'h0000;
  localparam logic [15:0] UTCC_TCC_WMASK = 16'hfc91;
  // transceiver_line_status fields
  localparam int UTCC_TLS_FIX_BIT = 6;
  localparam logic [15:0] UTCC_TLS_FIXED = 16'h0040;
  // clock select codes and matching pll multipliers
  localparam logic [1:0] UTCC_XTAL_12 = 2'h0;
  localparam logic [1:0] UTCC_XTAL_24 = 2'h1;
  localparam logic [1:0] UTCC_XTAL_48 = 2'h2;
  localparam logic [1:0] UTCC_XTAL_RSV = 2'h3;
  localparam logic [5:0] UTCC_MULT_12 = 6'h28;
  localparam logic [5:0] UTCC_MULT_24 = 6'h14;
  localparam logic [5:0] UTCC_MULT_48 = 6'h0a;
  localparam logic [5:0] UTCC_MULT_OFF = 6'h00;
  // line state codes
  localparam logic [1:0] UTCC_LS_SE0 = 2'h0;
  localparam logic [1:0] UTCC_LS_J = 2'h1;
  localparam logic [1:0] UTCC_LS_K = 2'h2;
  localparam logic [1:0] UTCC_LS_SE1 = 2'h3;
  // controller timing
  localparam int UTCC_CLK_MHZ = 10;
  localparam int UTCC_OSC_SETTLE_US = 100;
  localparam int UTCC_PLL_LOCK_US = 200;
  localparam int UTCC_OSC_CYC = UTCC_OSC_SETTLE_US * UTCC_CLK_MHZ;
  localparam int UTCC_PLL_CYC = UTCC_PLL_LOCK_US * UTCC_CLK_MHZ;
  localparam int UTCC_POLL_CYC = 16;
  localparam int UTCC_CW = 12;
  // controller software registers (word index)
  localparam logic [3:0] UTCC_CMD_OFS = 4'h0;
  localparam logic [3:0] UTCC_STAT_OFS = 4'h1;
  localparam int UTCC_CMD_UP = 0;
  localparam int UTCC_CMD_DOWN = 1;
  localparam int UTCC_CMD_XLO = 2;
  localparam int UTCC_CMD_XHI = 3;
  localparam int UTCC_CMD_HS = 4;
  localparam int UTCC_CMD_PU = 5;
  localparam logic [15:0] UTCC_CMD_RST = 16'h0000;
endpackage

// >>> rtl/utcc_link_if.sv
// register port joining the controller to the transceiver control block
`timescale 1ns/10ps
`default_nettype none
interface utcc_link_if;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport ctl (output addr, output wdata, output wr, output rd, input rdata);
endinterface
`default_nettype wire

// >>> rtl/utcc_device.sv
// device end: transceiver clock control and line status registers
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - bits 15:14 pick 12, 24 or 48 MHz
// - bit 13 enables oscillation buffer
// - resume from suspend sets oscillation buffer bit
// - bit 12 gates internal reference clock
// - bit 11 enables the pll
// - software waits for oscillator before ref/pll enable
// - bit 10 gates internal usb clock
// - software waits for pll before clock supply
// - bit 7 allows hi-speed, else full-speed only
// - software sets hi-speed bit before clock supply
// - bit 4 connects the d+ pull-up
// - bit 0 low holds module in reset
// - reset-initialised registers ignore writes while held
// - full-speed line status: se0, j, k, se1
// - hi-speed and chirp line status codes
// - line status field ignores writes
// - reserved control bits read zero, written zero
// - line status bit 6 reads one
module utcc_device
  import utcc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  utcc_link_if.dev link,
  input wire logic resume_in,
  input wire logic dplus_in,
  input wire logic dminus_in,
  input wire logic hs_mode_in,
  input wire logic chirp_in,
  input wire logic hs_unsquelch_in,
  output logic [5:0] pll_mult_out,
  output logic osc_buffer_enable_out,
  output logic ref_clock_supply_enable_out,
  output logic pll_run_enable_out,
  output logic internal_clock_supply_enable_out,
  output logic high_speed_enable_out,
  output logic dplus_pullup_enable_out,
  output logic module_soft_reset_out,
  output logic usb_logic_run_out,
  output logic [1:0] line_state_out
);

  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [1:0] line_state;
  logic [1:0] next_line_state;
  logic [15:0] rdata;
  logic [5:0] next_mult;
  logic [15:0] next_rdata;
  logic wr_ctrl;

  // full-speed, hi-speed or reset handshake decode of the bus lines
  typedef enum logic [2:0] {
    UTCC_LM_FS = 3'h1,
    UTCC_LM_HS = 3'h2,
    UTCC_LM_CHIRP = 3'h4
  } utcc_line_mode_t;

  utcc_line_mode_t line_mode;

  // one flop per clock or bus enable, in the order of the enable ports
  localparam int UTCC_EN_N = 6;
  localparam int UTCC_EN_POS [UTCC_EN_N] = '{UTCC_OSC_BIT, UTCC_REF_BIT, UTCC_PLL_BIT, UTCC_SCK_BIT,
    UTCC_HSE_BIT, UTCC_RPU_BIT};
  logic [UTCC_EN_N-1:0] en_q;

  // only the control word takes writes; status and unmapped offsets drop them
  assign wr_ctrl = link.wr && (link.addr == UTCC_TCC_OFS);

  // control register next value
  always_comb begin
    next_ctrl = ctrl;
    if (wr_ctrl) begin
      // this register is not cleared by the software reset, so it stays writable
      next_ctrl = link.wdata & UTCC_TCC_WMASK;
    end
    if (resume_in) begin
      // hardware set beats a same-cycle software clear
      next_ctrl[UTCC_OSC_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ctrl <= UTCC_TCC_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // pll multiplier for the selected external clock
  always_comb begin
    unique case (next_ctrl[UTCC_XTAL_HI:UTCC_XTAL_LO])
      UTCC_XTAL_12: next_mult = UTCC_MULT_12;
      UTCC_XTAL_24: next_mult = UTCC_MULT_24;
      UTCC_XTAL_48: next_mult = UTCC_MULT_48;
      UTCC_XTAL_RSV: next_mult = UTCC_MULT_OFF;
    endcase
  end

  // clock and bus controls, registered alongside the control word
  // they take next_ctrl so they change on the edge that loads the register
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pll_mult_out <= UTCC_MULT_12;
    end else begin
      pll_mult_out <= next_mult;
    end
  end

  for (genvar i = 0; i < UTCC_EN_N; i++) begin : g_en
    always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
        en_q[i] <= UTCC_TCC_RST[UTCC_EN_POS[i]];
      end else begin
        en_q[i] <= next_ctrl[UTCC_EN_POS[i]];
      end
    end
  end

  assign osc_buffer_enable_out = en_q[0];
  assign ref_clock_supply_enable_out = en_q[1];
  assign pll_run_enable_out = en_q[2];
  assign internal_clock_supply_enable_out = en_q[3];
  assign high_speed_enable_out = en_q[4];
  assign dplus_pullup_enable_out = en_q[5];

  // module reset and protocol clock run
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      module_soft_reset_out <= 1'b1;
      usb_logic_run_out <= 1'b0;
    end else begin
      module_soft_reset_out <= ~next_ctrl[UTCC_RUN_BIT];
      // nothing on the internal clock runs before pll and supply are both on
      usb_logic_run_out <= next_ctrl[UTCC_PLL_BIT] & next_ctrl[UTCC_SCK_BIT];
    end
  end

  // chirp outranks hi-speed, and both need hi-speed enabled
  always_comb begin
    line_mode = UTCC_LM_FS;
    if (chirp_in && ctrl[UTCC_HSE_BIT]) begin
      line_mode = UTCC_LM_CHIRP;
    end else if (hs_mode_in && ctrl[UTCC_HSE_BIT]) begin
      line_mode = UTCC_LM_HS;
    end
  end

  // line state decode per operating mode
  always_comb begin
    next_line_state = UTCC_LS_SE0;
    unique case (line_mode)
      UTCC_LM_CHIRP: begin
        // squelched lines read se0, otherwise d+ tells chirp j from chirp k
        if (hs_unsquelch_in) begin
          next_line_state = dplus_in ? UTCC_LS_J : UTCC_LS_K;
        end
      end
      UTCC_LM_HS: begin
        next_line_state = hs_unsquelch_in ? UTCC_LS_J : UTCC_LS_SE0;
      end
      UTCC_LM_FS: begin
        // full-speed: code is {d-, d+}
        next_line_state = {dminus_in, dplus_in};
      end
    endcase
  end

  // sampled bus state; no write path reaches it
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      line_state <= UTCC_LS_SE0;
      line_state_out <= UTCC_LS_SE0;
    end else begin
      line_state <= next_line_state;
      line_state_out <= next_line_state;
    end
  end

  // read data one cycle after the read strobe, zero otherwise
  // idle cycles read zero so a late sample cannot pass for an answer
  always_comb begin
    next_rdata = 16'h0000;
    if (link.rd && (link.addr == UTCC_TCC_OFS)) begin
      next_rdata = ctrl;
    end else if (link.rd && (link.addr == UTCC_TLS_OFS)) begin
      next_rdata = UTCC_TLS_FIXED | {14'h0000, line_state};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign link.rdata = rdata;

endmodule
`default_nettype wire

// >>> rtl/utcc_ctrl.sv
// controller end: brings the transceiver clocks up in order over the link
`timescale 1ns/10ps
`default_nettype none
module utcc_ctrl
  import utcc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  utcc_link_if.ctl link,
  input wire logic [3:0] sw_addr_in,
  input wire logic [15:0] sw_wdata_in,
  input wire logic sw_wr_in,
  input wire logic sw_rd_in,
  output logic [15:0] sw_rdata_out
);

  typedef enum logic [7:0] {
    UTCC_S_IDLE = 8'h01,
    UTCC_S_OSC = 8'h02,
    UTCC_S_WOSC = 8'h04,
    UTCC_S_PLL = 8'h08,
    UTCC_S_WPLL = 8'h10,
    UTCC_S_CLK = 8'h20,
    UTCC_S_RUN = 8'h40,
    UTCC_S_READY = 8'h80
  } utcc_state_t;

  utcc_state_t state;
  logic [15:0] cmd;
  logic [UTCC_CW-1:0] cnt;
  logic [1:0] seen_line;
  logic rd_pend;
  logic up_req;
  logic down_req;
  logic [15:0] base;

  assign up_req = sw_wr_in && (sw_addr_in == UTCC_CMD_OFS) && sw_wdata_in[UTCC_CMD_UP];
  assign down_req = sw_wr_in && (sw_addr_in == UTCC_CMD_OFS) && sw_wdata_in[UTCC_CMD_DOWN];
  // hi-speed choice goes out with the very first write
  assign base = ({14'h0000, cmd[UTCC_CMD_XHI:UTCC_CMD_XLO]} << UTCC_XTAL_LO)
              | ({15'h0000, cmd[UTCC_CMD_HS]} << UTCC_HSE_BIT)
              | (16'h0001 << UTCC_OSC_BIT);

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cmd <= UTCC_CMD_RST;
    end else if (sw_wr_in && (sw_addr_in == UTCC_CMD_OFS)) begin
      // bring-up and shut-down are pulses and are not stored
      cmd <= sw_wdata_in & ~((16'h0001 << UTCC_CMD_UP) | (16'h0001 << UTCC_CMD_DOWN));
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state <= UTCC_S_IDLE;
      cnt <= '0;
      link.addr <= UTCC_TCC_OFS;
      link.wdata <= 16'h0000;
      link.wr <= 1'b0;
      link.rd <= 1'b0;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      if (down_req) begin
        state <= UTCC_S_IDLE;
        link.addr <= UTCC_TCC_OFS;
        link.wdata <= 16'h0000;
        link.wr <= 1'b1;
      end else begin
        unique case (state)
          UTCC_S_IDLE: if (up_req) state <= UTCC_S_OSC;
          UTCC_S_OSC: begin
            link.addr <= UTCC_TCC_OFS;
            link.wdata <= base;
            link.wr <= 1'b1;
            cnt <= UTCC_CW'(UTCC_OSC_CYC);
            state <= UTCC_S_WOSC;
          end
          UTCC_S_WOSC: begin
            cnt <= cnt - 1'b1;
            if (cnt == '0) state <= UTCC_S_PLL;
          end
          UTCC_S_PLL: begin
            link.wdata <= base | (16'h0001 << UTCC_REF_BIT) | (16'h0001 << UTCC_PLL_BIT);
            link.wr <= 1'b1;
            cnt <= UTCC_CW'(UTCC_PLL_CYC);
            state <= UTCC_S_WPLL;
          end
          UTCC_S_WPLL: begin
            cnt <= cnt - 1'b1;
            if (cnt == '0) state <= UTCC_S_CLK;
          end
          UTCC_S_CLK: begin
            link.wdata <= link.wdata | (16'h0001 << UTCC_SCK_BIT);
            link.wr <= 1'b1;
            state <= UTCC_S_RUN;
          end
          UTCC_S_RUN: begin
            link.wdata <= link.wdata | (16'h0001 << UTCC_RUN_BIT)
                        | ({15'h0000, cmd[UTCC_CMD_PU]} << UTCC_RPU_BIT);
            link.wr <= 1'b1;
            cnt <= UTCC_CW'(UTCC_POLL_CYC);
            state <= UTCC_S_READY;
          end
          UTCC_S_READY: begin
            cnt <= cnt - 1'b1;
            if (cnt == '0) begin
              // periodic line status poll
              link.addr <= UTCC_TLS_OFS;
              link.rd <= 1'b1;
              cnt <= UTCC_CW'(UTCC_POLL_CYC);
            end else begin
              link.addr <= UTCC_TCC_OFS;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rd_pend <= 1'b0;
      seen_line <= UTCC_LS_SE0;
    end else begin
      rd_pend <= link.rd;
      if (rd_pend) seen_line <= link.rdata[1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      sw_rdata_out <= 16'h0000;
    end else if (sw_rd_in && (sw_addr_in == UTCC_CMD_OFS)) begin
      sw_rdata_out <= cmd;
    end else if (sw_rd_in && (sw_addr_in == UTCC_STAT_OFS)) begin
      sw_rdata_out <= {state, 4'h0, seen_line, (state != UTCC_S_IDLE && state != UTCC_S_READY),
                       (state == UTCC_S_READY)};
    end else begin
      sw_rdata_out <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// >>> tb/utcc_properties.sv
// link assertions between the controller and device ends
`timescale 1ns/10ps
`default_nettype none
module utcc_properties
  import utcc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  logic [15:0] last_w;
  logic [11:0] osc_cnt;
  logic [11:0] pll_cnt;
  wire logic cw = wr && addr == UTCC_TCC_OFS;
  // cycles since the oscillator and the pll were last started
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      last_w <= 16'h0000;
      osc_cnt <= 12'h000;
      pll_cnt <= 12'h000;
    end else begin
      if (cw)
        last_w <= wdata;
      if (cw && wdata[UTCC_OSC_BIT] && !wdata[UTCC_PLL_BIT])
        osc_cnt <= 12'h001;
      else if (osc_cnt != 12'hfff)
        osc_cnt <= osc_cnt + 12'h001;
      if (cw && wdata[UTCC_PLL_BIT] && !wdata[UTCC_SCK_BIT])
        pll_cnt <= 12'h001;
      else if (pll_cnt != 12'hfff)
        pll_cnt <= pll_cnt + 12'h001;
    end
  end
  sequence s_ls_rd;
    rd && addr == UTCC_TLS_OFS;
  endsequence
  sequence s_ls_ans;
    rdata[15:7] == 9'h000 && rdata[6] && rdata[5:2] == 4'h0;
  endsequence
  a_ls_fixed: assert property (s_ls_rd |=> s_ls_ans)
    else $error("line status fixed bits wrong");
  a_rsvd_wzero: assert property (cw |-> (wdata & ~UTCC_TCC_WMASK) == 16'h0000)
    else $error("reserved control bits written nonzero");
  a_pll_wait: assert property (cw && wdata[UTCC_PLL_BIT] && !last_w[UTCC_PLL_BIT] |-> osc_cnt >= UTCC_OSC_CYC)
    else $error("pll enabled before oscillator settled");
  a_ref_wait: assert property (cw && wdata[UTCC_REF_BIT] && !last_w[UTCC_REF_BIT] |-> osc_cnt >= UTCC_OSC_CYC)
    else $error("reference clock enabled before oscillator settled");
  a_sck_wait: assert property (cw && wdata[UTCC_SCK_BIT] && !last_w[UTCC_SCK_BIT] |->
    pll_cnt >= UTCC_PLL_CYC && wdata[UTCC_PLL_BIT])
    else $error("clock supply enabled before pll lock");
  a_hse_first: assert property (cw && wdata[UTCC_SCK_BIT] && !last_w[UTCC_SCK_BIT] |->
    wdata[UTCC_HSE_BIT] == last_w[UTCC_HSE_BIT])
    else $error("hi-speed bit changed with clock supply");
  a_run_last: assert property (cw && wdata[UTCC_RUN_BIT] |-> last_w[UTCC_SCK_BIT] && last_w[UTCC_PLL_BIT])
    else $error("module released before clocks running");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside answer cycle");
endmodule
`default_nettype wire

// >>> tb/usb_transceiver_clock_control_tb_top.sv
// self-checking bench joining the controller and device ends
`timescale 1ns/10ps
`default_nettype none
module usb_transceiver_clock_control_tb_top
  import utcc_pkg::*;
;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic resume_in = 1'b0;
  logic [4:0] lv = 5'h00; // hs mode, chirp, unsquelch, d-, d+
  logic [3:0] sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  wire logic [15:0] sw_rdata;
  wire logic [5:0] mult;
  wire logic [7:0] en;
  wire logic [1:0] ls;
  int err_count = 0;
  int num_checks = 0;
  logic [15:0] d;
  utcc_link_if link ();
  always #50 clk_sys_in = ~clk_sys_in;
  utcc_device u_utcc_device (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(link), .resume_in(resume_in),
    .dplus_in(lv[0]), .dminus_in(lv[1]), .hs_mode_in(lv[4]), .chirp_in(lv[3]), .hs_unsquelch_in(lv[2]),
    .pll_mult_out(mult), .osc_buffer_enable_out(en[7]), .ref_clock_supply_enable_out(en[6]),
    .pll_run_enable_out(en[5]), .internal_clock_supply_enable_out(en[4]), .high_speed_enable_out(en[3]),
    .dplus_pullup_enable_out(en[2]), .module_soft_reset_out(en[1]), .usb_logic_run_out(en[0]), .line_state_out(ls));
  utcc_ctrl u_utcc_ctrl (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .link(link), .sw_addr_in(sw_addr),
    .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr), .sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata));
  utcc_properties u_utcc_properties (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .addr(link.addr),
    .wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_sys_in);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clk_sys_in);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_sys_in);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys_in);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask
  task automatic wait_ready();
    d = 16'h0000;
    for (int i = 0; i < 3000 && d[0] !== 1'b1; i++)
      sw_read(UTCC_STAT_OFS, d);
    if (d[0] !== 1'b1) begin
      err_count++;
      finish_test();
    end
  endtask
  // outputs packed as multiplier then osc, ref, pll, sck, hse, pull-up, held, run
  function automatic logic [15:0] outs_exp(input logic [1:0] x, input logic hs, input logic up);
    logic [5:0] m;
    m = x == UTCC_XTAL_12 ? UTCC_MULT_12 : x == UTCC_XTAL_24 ? UTCC_MULT_24 :
      x == UTCC_XTAL_48 ? UTCC_MULT_48 : UTCC_MULT_OFF;
    return up ? {2'h0, m, 4'hf, hs, 3'h5} : {2'h0, UTCC_MULT_12, 8'h02};
  endfunction
  function automatic logic [1:0] ls_exp(input logic high_speed_enable, input logic [4:0] v);
    if (v[3] && high_speed_enable)
      return v[2] ? (v[0] ? UTCC_LS_J : UTCC_LS_K) : UTCC_LS_SE0;
    if (v[4] && high_speed_enable)
      return v[2] ? UTCC_LS_J : UTCC_LS_SE0;
    return v[1:0];
  endfunction
  initial begin
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    #1 chk("outputs", outs_exp(2'h0, 1'b0, 1'b0), {2'h0, mult, en});
    sw_read(UTCC_STAT_OFS, d);
    chk("status", 16'h0100, d);
    sw_read(4'h2, d);
    chk("unmapped", 16'h0000, d);
    for (int x = 0; x < 4; x++) begin
      sw_write(UTCC_CMD_OFS, {10'h000, 1'b1, x[0], x[1:0], 2'h1});
      wait_ready();
      chk("outputs", outs_exp(x[1:0], x[0], 1'b1), {2'h0, mult, en});
      for (int v = 0; v < 32; v++) begin
        @(posedge clk_sys_in);
        lv <= 5'(v);
        @(posedge clk_sys_in);
        #1 chk("line_state", {14'h0000, ls_exp(x[0], 5'(v))}, {14'h0000, ls});
      end
      // a second bring-up while ready must be ignored
      sw_write(UTCC_CMD_OFS, 16'h0001);
      repeat (40) @(posedge clk_sys_in);
      sw_read(UTCC_STAT_OFS, d);
      chk("status", {8'h80, 4'h0, ls_exp(x[0], 5'h1f), 2'h1}, d);
      sw_write(UTCC_CMD_OFS, 16'h0002);
      repeat (3) @(posedge clk_sys_in);
      #1 chk("outputs", outs_exp(2'h0, 1'b0, 1'b0), {2'h0, mult, en});
      @(posedge clk_sys_in);
      resume_in <= 1'b1;
      @(posedge clk_sys_in);
      resume_in <= 1'b0;
      #1 chk("osc_buffer", 16'h0001, {15'h0000, en[7]});
    end
    finish_test();
  end
endmodule
`default_nettype wire
